//--- inc/pef_pkg.sv
/*
  Shared constants for the timing-event flag and stamp register bank.
  Assumes a 32-bit APB with byte addresses and one register per aligned word.
*/
package pef_pkg;
  localparam logic [7:0] ADDR_ENABLE_MASK = 8'h04;
  localparam logic [7:0] ADDR_MASKED_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_RAW_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_TX_LOW = 8'h10;
  localparam logic [7:0] ADDR_TX_HIGH = 8'h14;
  localparam logic [7:0] ADDR_TX_IDENT = 8'h18;
  localparam logic [7:0] ADDR_RX_LOW = 8'h1c;
  localparam logic [7:0] ADDR_RX_HIGH = 8'h20;
  // Flag positions
  localparam int BIT_TX_FRAME = 0;
  localparam int BIT_RX_FRAME = 1;
  localparam int BIT_TRIG_BASE = 2;
  localparam int BIT_CAPT_BASE = 5;
  localparam int NUM_FLAGS = 8;
  localparam int IDENT_SEQ_LSB = 16;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
endpackage

//--- src/pef_edge_sync.sv
/*
  Two-flop synchroniser with rising-edge pulse, one per input bit.
  Assumes inputs come from pins outside the pclk domain.
*/
`timescale 1ns/1ns
module pef_edge_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and pulses
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] rise_pulse
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] rise;
  } pef_sync_t;
  pef_sync_t s_q;
  pef_sync_t s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d = s_q;
    s_d.meta = pin_in;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
    s_d.rise = s_q.sync & ~s_q.last;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise_pulse = s_q.rise;
endmodule

//--- src/pef_event_regs.sv
/*
  Event flag and timestamp holding registers of a timing-frame stamping unit,
  reached over APB. Assumes the clock comparators and frame parser run on
  pclk and present one-cycle pulses with stamp data valid in that cycle;
  capture inputs are pins and are synchronised here.
*/
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module pef_event_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture pins, bit 2 is input two
  input wire logic [2:0] capture_input,
  // Trigger match pulses from the comparators
  input wire logic [2:0] trigger_match,
  // Receive frame event and stamp
  input wire logic rx_frame_seen,
  input wire logic [31:0] rx_stamp_low_in,
  input wire logic [31:0] rx_stamp_high_in,
  // Transmit frame event, stamp and header ident
  input wire logic tx_frame_seen,
  input wire logic [31:0] tx_stamp_low_in,
  input wire logic [31:0] tx_stamp_high_in,
  input wire logic [15:0] tx_sequence_ident,
  input wire logic [15:0] tx_source_port_number,
  // Stamp reservation state and interrupt
  output logic rx_detect_armed,
  output logic tx_detect_armed,
  output logic event_irq
);
  localparam int NF = pef_pkg::NUM_FLAGS;

  typedef struct packed {
    logic [NF-1:0] raw_event_flags;
    logic [NF-1:0] event_enable_mask;
    logic [31:0] tx_stamp_low_word;
    logic [31:0] tx_stamp_high_word;
    logic [31:0] tx_stamp_frame_ident;
    logic [31:0] rx_stamp_low_word;
    logic [31:0] rx_stamp_high_word;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic rx_armed;
    logic tx_armed;
  } pef_regs_t;

  // Reset image: all zero, except that both frame directions start armed
  localparam pef_regs_t REGS_RESET = '{
    raw_event_flags: pef_pkg::RESET_FLAGS,
    event_enable_mask: pef_pkg::RESET_FLAGS,
    tx_stamp_low_word: pef_pkg::RESET_WORD,
    tx_stamp_high_word: pef_pkg::RESET_WORD,
    tx_stamp_frame_ident: pef_pkg::RESET_WORD,
    rx_stamp_low_word: pef_pkg::RESET_WORD,
    rx_stamp_high_word: pef_pkg::RESET_WORD,
    rdata: pef_pkg::RESET_WORD,
    ready: 1'b0,
    err: 1'b0,
    irq: 1'b0,
    rx_armed: 1'b1,
    tx_armed: 1'b1
  };

  pef_regs_t r_q;
  pef_regs_t r_d;
  logic [2:0] capture_rise;
  logic [NF-1:0] set_vec;
  logic [NF-1:0] clr_vec;
  logic rx_take;
  logic tx_take;
  logic wr_acc;
  logic rd_acc;

  // Capture pins cross into pclk before edge detection
  pef_edge_sync #(
    .WIDTH(3)
  ) u_capture_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(capture_input),
    .rise_pulse(capture_rise)
  );

  // True for offsets that answer without error
  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      pef_pkg::ADDR_ENABLE_MASK, pef_pkg::ADDR_MASKED_FLAGS, pef_pkg::ADDR_RAW_FLAGS,
      pef_pkg::ADDR_TX_LOW, pef_pkg::ADDR_TX_HIGH, pef_pkg::ADDR_TX_IDENT,
      pef_pkg::ADDR_RX_LOW, pef_pkg::ADDR_RX_HIGH: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // Frames are taken only while their flag is clear; a set flag reserves the stamp
  assign rx_take = rx_frame_seen && !r_q.raw_event_flags[pef_pkg::BIT_RX_FRAME];
  assign tx_take = tx_frame_seen && !r_q.raw_event_flags[pef_pkg::BIT_TX_FRAME];

  // Zero-wait APB: setup cycle then access cycle with pready already high
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  // Hardware event set vector
  always_comb begin
    set_vec = '0;
    set_vec[pef_pkg::BIT_CAPT_BASE +: 3] = capture_rise;
    set_vec[pef_pkg::BIT_TRIG_BASE +: 3] = trigger_match;
    set_vec[pef_pkg::BIT_RX_FRAME] = rx_take;
    set_vec[pef_pkg::BIT_TX_FRAME] = tx_take;
  end

  // Write-one-to-clear vector, taken only on a write to the flag word
  assign clr_vec = (wr_acc && paddr == pef_pkg::ADDR_RAW_FLAGS) ? pwdata[NF-1:0] : '0;

  // Next state of the whole bank
  always_comb begin
    r_d = r_q;
    // Set beats clear so no event is dropped
    r_d.raw_event_flags = (r_q.raw_event_flags & ~clr_vec) | set_vec;
    if (wr_acc && paddr == pef_pkg::ADDR_ENABLE_MASK) begin
      r_d.event_enable_mask = pwdata[NF-1:0];
    end
    // Stamps load in the same cycle their flag sets
    if (tx_take) begin
      r_d.tx_stamp_low_word = tx_stamp_low_in;
      r_d.tx_stamp_high_word = tx_stamp_high_in;
      r_d.tx_stamp_frame_ident = {tx_sequence_ident, tx_source_port_number};
    end
    if (rx_take) begin
      r_d.rx_stamp_low_word = rx_stamp_low_in;
      r_d.rx_stamp_high_word = rx_stamp_high_in;
    end
    // Read data registered in setup cycle, valid in access cycle
    r_d.rdata = pef_pkg::RESET_WORD;
    if (rd_acc) begin
      case (paddr)
        pef_pkg::ADDR_ENABLE_MASK: r_d.rdata = {24'h000000, r_q.event_enable_mask};
        pef_pkg::ADDR_MASKED_FLAGS:
          r_d.rdata = {24'h000000, r_q.event_enable_mask & r_q.raw_event_flags};
        pef_pkg::ADDR_RAW_FLAGS: r_d.rdata = {24'h000000, r_q.raw_event_flags};
        pef_pkg::ADDR_TX_LOW: r_d.rdata = r_q.tx_stamp_low_word;
        pef_pkg::ADDR_TX_HIGH: r_d.rdata = r_q.tx_stamp_high_word;
        pef_pkg::ADDR_TX_IDENT: r_d.rdata = r_q.tx_stamp_frame_ident;
        pef_pkg::ADDR_RX_LOW: r_d.rdata = r_q.rx_stamp_low_word;
        pef_pkg::ADDR_RX_HIGH: r_d.rdata = r_q.rx_stamp_high_word;
        default: r_d.rdata = pef_pkg::RESET_WORD;
      endcase
    end
    r_d.ready = psel && !penable;
    r_d.err = psel && !penable && !addr_known(paddr);
    // Registered one cycle after the flags, so the pin stays a flop output
    r_d.irq = |(r_q.event_enable_mask & r_q.raw_event_flags);
    // Armed follows the next flag value, so these pins are plain flop outputs
    r_d.rx_armed = !r_d.raw_event_flags[pef_pkg::BIT_RX_FRAME];
    r_d.tx_armed = !r_d.raw_event_flags[pef_pkg::BIT_TX_FRAME];
  end

  // Single register, asynchronous active-low reset to REGS_RESET (zero except both armed bits)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= REGS_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.rdata;
  assign pready = r_q.ready;
  assign pslverr = r_q.err;
  assign event_irq = r_q.irq;
  assign rx_detect_armed = r_q.rx_armed;
  assign tx_detect_armed = r_q.tx_armed;

  // Assertions
  property p_capture_sets;
    @(posedge pclk) disable iff (!presetn)
      capture_rise[2] |=> r_q.raw_event_flags[7];
  endproperty
  a_capture_sets: assert property (p_capture_sets) else $error("capture flag not set");

  property p_trigger_sets;
    @(posedge pclk) disable iff (!presetn)
      trigger_match[0] |=> r_q.raw_event_flags[2];
  endproperty
  a_trigger_sets: assert property (p_trigger_sets) else $error("trigger flag not set");

  sequence s_rx_free_frame;
    rx_frame_seen && !r_q.raw_event_flags[1];
  endsequence
  property p_rx_sets;
    @(posedge pclk) disable iff (!presetn)
      s_rx_free_frame |=> r_q.raw_event_flags[1] && r_q.rx_stamp_low_word == $past(rx_stamp_low_in);
  endproperty
  a_rx_sets: assert property (p_rx_sets) else $error("rx flag or stamp wrong");

  property p_tx_sets;
    @(posedge pclk) disable iff (!presetn)
      tx_frame_seen && tx_detect_armed |=> r_q.raw_event_flags[0]
        && r_q.tx_stamp_frame_ident == {$past(tx_sequence_ident), $past(tx_source_port_number)};
  endproperty
  a_tx_sets: assert property (p_tx_sets) else $error("tx flag or ident wrong");

  property p_zero_keeps;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == 8'h0c && !pwdata[6] && r_q.raw_event_flags[6] |=> r_q.raw_event_flags[6];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

  property p_rx_hold;
    @(posedge pclk) disable iff (!presetn)
      r_q.raw_event_flags[1] && !(wr_acc && paddr == 8'h0c && pwdata[1])
        |=> $stable(r_q.rx_stamp_low_word) && r_q.raw_event_flags[1];
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx stamp overwritten");

  property p_tx_hold;
    @(posedge pclk) disable iff (!presetn)
      r_q.raw_event_flags[0] |=> $stable(r_q.tx_stamp_low_word) && $stable(r_q.tx_stamp_high_word);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx stamp overwritten");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      trigger_match[1] && wr_acc && paddr == 8'h0c && pwdata[3] |=> r_q.raw_event_flags[3];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      ##1 event_irq == |($past(r_q.event_enable_mask) & $past(r_q.raw_event_flags));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  // Capture path: each pin reaches its own flag through the synchroniser
  property p_cap_one;
    @(posedge pclk) disable iff (!presetn)
      capture_rise[1] |=> r_q.raw_event_flags[6];
  endproperty
  a_cap_one: assert property (p_cap_one) else $error("capture 1 flag not set");

  property p_cap_zero;
    @(posedge pclk) disable iff (!presetn)
      capture_rise[0] |=> r_q.raw_event_flags[5];
  endproperty
  a_cap_zero: assert property (p_cap_zero) else $error("capture 0 flag not set");

  // A pin edge must show in its flag within the synchroniser latency
  sequence s_pin_zero_rises;
    !capture_input[0] ##1 capture_input[0];
  endsequence
  property p_pin_to_flag;
    @(posedge pclk) disable iff (!presetn)
      s_pin_zero_rises |-> ##[1:5] r_q.raw_event_flags[5];
  endproperty
  a_pin_to_flag: assert property (p_pin_to_flag) else $error("pin edge lost");

  property p_trig_two;
    @(posedge pclk) disable iff (!presetn)
      trigger_match[2] |=> r_q.raw_event_flags[4];
  endproperty
  a_trig_two: assert property (p_trig_two) else $error("trigger 2 flag not set");

  // Clear path: a one clears a flag that hardware is not setting
  property p_clear_works;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == pef_pkg::ADDR_RAW_FLAGS && pwdata[5] && !set_vec[5]
        |=> !r_q.raw_event_flags[5];
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("one write kept flag");

  // Reservation: armed pins track the frame flags
  property p_rx_armed;
    @(posedge pclk) disable iff (!presetn)
      rx_detect_armed != r_q.raw_event_flags[pef_pkg::BIT_RX_FRAME];
  endproperty
  a_rx_armed: assert property (p_rx_armed) else $error("rx armed wrong");

  property p_tx_armed;
    @(posedge pclk) disable iff (!presetn)
      tx_detect_armed != r_q.raw_event_flags[pef_pkg::BIT_TX_FRAME];
  endproperty
  a_tx_armed: assert property (p_tx_armed) else $error("tx armed wrong");

  property p_rx_high_hold;
    @(posedge pclk) disable iff (!presetn)
      r_q.raw_event_flags[1] && !(wr_acc && paddr == 8'h0c && pwdata[1])
        |=> $stable(r_q.rx_stamp_high_word);
  endproperty
  a_rx_high_hold: assert property (p_rx_high_hold) else $error("rx high overwritten");

  property p_tx_ident_hold;
    @(posedge pclk) disable iff (!presetn)
      r_q.raw_event_flags[0] |=> $stable(r_q.tx_stamp_frame_ident);
  endproperty
  a_tx_ident_hold: assert property (p_tx_ident_hold) else $error("tx ident overwritten");

  // Stamp capture: both words follow the frame that set the flag
  sequence s_tx_free_frame;
    tx_frame_seen && tx_detect_armed;
  endsequence
  property p_tx_words;
    @(posedge pclk) disable iff (!presetn)
      s_tx_free_frame |=> r_q.tx_stamp_low_word == $past(tx_stamp_low_in)
        && r_q.tx_stamp_high_word == $past(tx_stamp_high_in);
  endproperty
  a_tx_words: assert property (p_tx_words) else $error("tx stamp words wrong");

  // Read-only words ignore writes
  property p_tx_low_ro;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == pef_pkg::ADDR_TX_LOW && !tx_take |=> $stable(r_q.tx_stamp_low_word);
  endproperty
  a_tx_low_ro: assert property (p_tx_low_ro) else $error("tx low written");

  property p_rx_low_ro;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == pef_pkg::ADDR_RX_LOW && !rx_take |=> $stable(r_q.rx_stamp_low_word);
  endproperty
  a_rx_low_ro: assert property (p_rx_low_ro) else $error("rx low written");

  // Read path: the word read stands with pready in the access cycle
  property p_raw_read;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && pready && paddr == pef_pkg::ADDR_RAW_FLAGS
        |-> prdata == {24'h000000, $past(r_q.raw_event_flags)};
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("flag read wrong");

  property p_masked_read;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && pready && paddr == pef_pkg::ADDR_MASKED_FLAGS
        |-> prdata == {24'h000000, $past(r_q.event_enable_mask) & $past(r_q.raw_event_flags)};
  endproperty
  a_masked_read: assert property (p_masked_read) else $error("masked read wrong");

  // Interrupt drops once nothing enabled is pending
  property p_irq_off;
    @(posedge pclk) disable iff (!presetn)
      !(|(r_q.event_enable_mask & r_q.raw_event_flags)) |=> !event_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq stuck high");
endmodule

//--- verif/pef_event_regs_tb.sv
/*
  Self-checking bench for the event flag and stamp register bank.
  Assumes an APB slave that answers in its own time; a bench model predicts every read.
*/
`timescale 1ns/1ns
module pef_event_regs_tb;
  // Design ports
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rx_lo, rx_hi, tx_lo, tx_hi;
  logic [2:0] cap, trig;
  logic rx_seen, tx_seen, rx_armed, tx_armed, event_irq;
  logic [15:0] tx_seq, tx_port;
  // Model state and bookkeeping
  int n_mismatch, samples_checked, seed, m_flags, m_mask;
  logic [31:0] m_txl, m_txh, m_txid, m_rxl, m_rxh, rdat, id;
  logic rerr;

  pef_event_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_input(cap), .trigger_match(trig),
    .rx_frame_seen(rx_seen), .rx_stamp_low_in(rx_lo), .rx_stamp_high_in(rx_hi),
    .tx_frame_seen(tx_seen), .tx_stamp_low_in(tx_lo), .tx_stamp_high_in(tx_hi),
    .tx_sequence_ident(tx_seq), .tx_source_port_number(tx_port),
    .rx_detect_armed(rx_armed), .tx_detect_armed(tx_armed), .event_irq(event_irq));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; pready, read data and error are taken at one rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [2:0] tg);
    int n;
    logic got;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    trig <= tg;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    got = (pready === 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    trig <= 3'h0;
    // Idle edge, so the next setup never overrides this release in one step
    @(posedge pclk);
    if (!got) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // Write and mirror its effect; a trigger set wins over a same-edge clear
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] tg);
    apb(1'b1, a, d, tg);
    if (a == pef_pkg::ADDR_ENABLE_MASK) m_mask = int'(d[7:0]);
    if (a == pef_pkg::ADDR_RAW_FLAGS) m_flags = m_flags & ~int'(d[7:0]);
    m_flags = m_flags | (int'(tg) << 2);
  endtask

  function automatic logic [31:0] exp_of(input logic [7:0] a);
    case (a)
      pef_pkg::ADDR_ENABLE_MASK: return 32'(m_mask);
      pef_pkg::ADDR_MASKED_FLAGS: return 32'(m_flags & m_mask);
      pef_pkg::ADDR_RAW_FLAGS: return 32'(m_flags);
      pef_pkg::ADDR_TX_LOW: return m_txl;
      pef_pkg::ADDR_TX_HIGH: return m_txh;
      pef_pkg::ADDR_TX_IDENT: return m_txid;
      pef_pkg::ADDR_RX_LOW: return m_rxl;
      pef_pkg::ADDR_RX_HIGH: return m_rxh;
      default: return 32'h00000000;
    endcase
  endfunction

  task automatic rd_chk(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000, 3'h0);
    chk(rdat, exp_of(a));
    chk({31'h0, rerr}, {31'h0, (a < 8'h04 || a > 8'h20)});
  endtask

  task automatic irq_chk();
    @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, event_irq}, {31'h0, (m_flags & m_mask) != 0});
    chk({30'h0, rx_armed, tx_armed}, {30'h0, !m_flags[1], !m_flags[0]});
    @(posedge pclk);
  endtask

  task automatic all_chk();
    for (int a = 0; a <= 36; a += 4) rd_chk(8'(a));
  endtask

  // Frame pulse with fresh random stamps; ignored while its flag is set
  task automatic frame(input logic tx);
    id = $random(seed);
    tx_lo <= $random(seed);
    tx_hi <= $random(seed);
    rx_lo <= $random(seed);
    rx_hi <= $random(seed);
    tx_seq <= id[31:16];
    tx_port <= id[15:0];
    if (tx) tx_seen <= 1'b1;
    else rx_seen <= 1'b1;
    @(posedge pclk);
    tx_seen <= 1'b0;
    rx_seen <= 1'b0;
    if (tx && !m_flags[0]) begin
      {m_txl, m_txh, m_txid} = {tx_lo, tx_hi, id};
      m_flags = m_flags | 1;
    end
    if (!tx && !m_flags[1]) begin
      {m_rxl, m_rxh} = {rx_lo, rx_hi};
      m_flags = m_flags | 2;
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    {m_flags, m_mask} = '0;
    {m_txl, m_txh, m_txid, m_rxl, m_rxh} = '0;
    @(posedge pclk);
  endtask

  initial begin
    seed = 41025;
    {psel, penable, pwrite, paddr, pwdata, cap, trig, rx_seen, tx_seen} = '0;
    {rx_lo, rx_hi, tx_lo, tx_hi, tx_seq, tx_port, id} = '0;
    presetn = 1'b0;
    do_reset();
    all_chk();
    // Writes everywhere: read-only and unmapped places must not change
    for (int a = 0; a <= 36; a += 4) wr(8'(a), $random(seed), 3'h0);
    wr(pef_pkg::ADDR_ENABLE_MASK, 32'hffffffff, 3'h0);
    all_chk();
    for (int i = 0; i < 3; i++) begin
      trig <= 3'(1 << i);
      @(posedge pclk);
      trig <= 3'h0;
      m_flags = m_flags | (1 << (i + 2));
      irq_chk();
      cap[i] <= 1'b1;
      repeat (6) @(posedge pclk);
      cap[i] <= 1'b0;
      m_flags = m_flags | (1 << (i + 5));
      rd_chk(pef_pkg::ADDR_RAW_FLAGS);
    end
    wr(pef_pkg::ADDR_RAW_FLAGS, 32'hffffff00, 3'h0);
    rd_chk(pef_pkg::ADDR_RAW_FLAGS);
    wr(pef_pkg::ADDR_RAW_FLAGS, 32'h000000fc, 3'h0);
    irq_chk();
    // Second frame while flag is set must leave the stamp alone
    for (int t = 0; t < 2; t++) begin
      frame(t[0]);
      irq_chk();
      frame(t[0]);
      irq_chk();
      all_chk();
      wr(pef_pkg::ADDR_RAW_FLAGS, 32'(t[0] ? 1 : 2), 3'h0);
      frame(t[0]);
      all_chk();
    end
    wr(pef_pkg::ADDR_RAW_FLAGS, 32'h000000ff, 3'h7);
    rd_chk(pef_pkg::ADDR_RAW_FLAGS);
    for (int i = 0; i < 4; i++) begin
      wr(pef_pkg::ADDR_ENABLE_MASK, $random(seed), 3'h0);
      rd_chk(pef_pkg::ADDR_MASKED_FLAGS);
      irq_chk();
    end
    do_reset();
    all_chk();
    stop_test();
  end
endmodule
